//--- src/sec_eeprom_cmd.sv
// Serial EEPROM command front end: decode, status, hold, write cycle
`timescale 1ns/100ps
`include "sec_defines.svh"
module sec_eeprom_cmd
    import sec_pkg::*;
#(
    parameter int WC_CYCLES = `SEC_WC_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Serial pins
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic so_out,
    output logic so_oe,
    // Memory port
    output logic [16:0] mem_addr,
    output logic mem_id_sel,
    output logic [7:0] mem_wdata,
    output logic mem_wr_pulse,
    output logic mem_commit,
    input wire logic [7:0] mem_rdata,
    // Status
    output logic [7:0] status_out,
    output logic busy
);
    localparam int WCW = $clog2(WC_CYCLES + 1);

    generate
        if (WC_CYCLES < 2) begin : g_chk
            $error("WC_CYCLES must be at least 2");
        end
    endgenerate

    sec_pin_if pin();

    sec_pin_sync u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .pins_raw({wp_n, hold_n, cs_n, si, sck}),
        .pin(pin)
    );

    sec_state_e state_reg, state_next;
    sec_cmd_e cmd_reg, cmd_next;
    logic [4:0] bit_cnt_reg, bit_cnt_next;
    logic [23:0] sh_reg, sh_next;
    logic [2:0] out_cnt_reg, out_cnt_next;
    logic [7:0] out_sh_reg, out_sh_next;
    logic so_reg, so_next;
    logic done_reg, done_next;
    logic ppe_reg, ppe_next;
    logic ids_reg, ids_next;
    logic lock_reg, lock_next;
    logic [1:0] bp_reg, bp_next;
    logic wel_reg, wel_next;
    logic busy_reg, busy_next;
    logic [WCW-1:0] wc_cnt_reg, wc_cnt_next;
    logic [16:0] addr_reg, addr_next;
    logic [7:0] wdata_reg, wdata_next;
    logic wr_pulse_reg, wr_pulse_next;
    logic commit_reg, commit_next;
    logic [7:0] stat_data_reg, stat_data_next;
    logic [7:0] status;
    logic [7:0] opcode;
    logic [7:0] ld_byte;
    logic hw_prot;
    logic stat_commit;

    assign status = {ppe_reg, ids_reg, 1'b0, lock_reg, bp_reg, wel_reg, busy_reg};
    assign opcode = {sh_reg[6:0], pin.si};
    assign hw_prot = ~pin.wp_n & ppe_reg;
    assign ld_byte = (state_reg == SEC_RSTAT) ? status : mem_rdata;
    assign stat_commit = pin.cs_rise & (cmd_reg == SEC_CMD_WRS) & done_reg & ~busy_reg
        & wel_reg & ~hw_prot;

    always_comb begin
        state_next = state_reg;
        cmd_next = cmd_reg;
        bit_cnt_next = bit_cnt_reg;
        sh_next = sh_reg;
        out_cnt_next = out_cnt_reg;
        out_sh_next = out_sh_reg;
        so_next = so_reg;
        done_next = done_reg;
        ppe_next = ppe_reg;
        ids_next = ids_reg;
        lock_next = lock_reg;
        bp_next = bp_reg;
        wel_next = wel_reg;
        busy_next = busy_reg;
        wc_cnt_next = wc_cnt_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        wr_pulse_next = 1'b0;
        commit_next = 1'b0;
        stat_data_next = stat_data_reg;

        // Self-timed write cycle
        if (busy_reg) begin
            if (wc_cnt_reg == WCW'(1)) begin
                busy_next = 1'b0;
                wel_next = 1'b0;
            end
            wc_cnt_next = wc_cnt_reg - WCW'(1);
        end

        // Byte address steps after each write, wrapping in the page
        if (wr_pulse_reg) begin
            addr_next[7:0] = addr_reg[7:0] + 8'h01;
        end

        if (pin.cs_fall) begin
            // Session opens; a fresh instruction follows
            state_next = SEC_OPC;
            cmd_next = SEC_CMD_NONE;
            bit_cnt_next = 5'h00;
            out_cnt_next = 3'h0;
            done_next = 1'b0;
        end else if (pin.cs_rise) begin
            // Effects land only on the closing edge, so aborted frames do nothing
            state_next = SEC_IDLE;
            if (done_reg && !busy_reg) begin
                case (cmd_reg)
                    SEC_CMD_SETW: wel_next = 1'b1;
                    SEC_CMD_CLRW: wel_next = 1'b0;
                    SEC_CMD_RD: ids_next = 1'b0;
                    SEC_CMD_WR: begin
                        commit_next = 1'b1;
                        ids_next = 1'b0;
                        busy_next = 1'b1;
                        wc_cnt_next = WCW'(WC_CYCLES);
                    end
                    default: ;
                endcase
            end
            if (stat_commit) begin
                ppe_next = stat_data_reg[`SEC_ST_PPE];
                bp_next = stat_data_reg[`SEC_ST_BP_HI:`SEC_ST_BP_LO];
                // Setting page select and lock together changes neither
                if (!(stat_data_reg[`SEC_ST_IDS] && stat_data_reg[`SEC_ST_LOCK])) begin
                    ids_next = stat_data_reg[`SEC_ST_IDS];
                    lock_next = lock_reg | stat_data_reg[`SEC_ST_LOCK];
                end
                busy_next = 1'b1;
                wc_cnt_next = WCW'(WC_CYCLES);
            end
        end else if (!pin.cs_n && pin.hold_n) begin
            if (pin.sck_rise) begin
                sh_next = {sh_reg[22:0], pin.si};
                bit_cnt_next = bit_cnt_reg + 5'h01;
                case (state_reg)
                    SEC_OPC: begin
                        if (bit_cnt_reg == `SEC_OPC_LAST) begin
                            state_next = SEC_IGNORE;
                            if (busy_reg && opcode != `SEC_OP_RD_STAT) begin
                                state_next = SEC_IGNORE;
                            end else begin
                                case (opcode)
                                    `SEC_OP_SET_WEL: begin
                                        cmd_next = SEC_CMD_SETW;
                                        done_next = 1'b1;
                                        state_next = SEC_IGNORE;
                                    end
                                    `SEC_OP_CLR_WEL: begin
                                        cmd_next = SEC_CMD_CLRW;
                                        done_next = 1'b1;
                                        state_next = SEC_IGNORE;
                                    end
                                    `SEC_OP_RD_STAT: begin
                                        cmd_next = SEC_CMD_RDS;
                                        state_next = SEC_RSTAT;
                                    end
                                    `SEC_OP_WR_STAT: begin
                                        cmd_next = SEC_CMD_WRS;
                                        state_next = SEC_WSTAT;
                                    end
                                    `SEC_OP_MEM_RD: begin
                                        cmd_next = SEC_CMD_RD;
                                        state_next = SEC_ADDR;
                                    end
                                    `SEC_OP_MEM_WR: begin
                                        cmd_next = SEC_CMD_WR;
                                        // Locked ID page or no latch: whole frame dropped
                                        if (wel_reg && !(ids_reg && lock_reg)) begin
                                            state_next = SEC_ADDR;
                                        end
                                    end
                                    default: state_next = SEC_IGNORE;
                                endcase
                            end
                        end
                    end
                    SEC_ADDR: begin
                        if (bit_cnt_reg == `SEC_ADDR_LAST) begin
                            addr_next = sh_next[16:0];
                            if (cmd_reg == SEC_CMD_RD) begin
                                done_next = 1'b1;
                                state_next = SEC_RDATA;
                            end else begin
                                state_next = SEC_WDATA;
                            end
                        end
                    end
                    SEC_WDATA: begin
                        if (bit_cnt_reg[2:0] == 3'h7) begin
                            wdata_next = sh_next[7:0];
                            wr_pulse_next = 1'b1;
                            done_next = 1'b1;
                        end
                    end
                    SEC_WSTAT: begin
                        if (bit_cnt_reg == `SEC_STAT_LAST) begin
                            stat_data_next = sh_next[7:0];
                            done_next = 1'b1;
                            state_next = SEC_IGNORE;
                        end
                    end
                    default: ;
                endcase
            end else if (pin.sck_fall && (state_reg == SEC_RDATA || state_reg == SEC_RSTAT)) begin
                if (out_cnt_reg == 3'h0) begin
                    so_next = ld_byte[7];
                    out_sh_next = {ld_byte[6:0], 1'b0};
                    out_cnt_next = 3'h7;
                    if (state_reg == SEC_RDATA) begin
                        if (ids_reg) begin
                            addr_next[7:0] = addr_reg[7:0] + 8'h01;
                        end else begin
                            addr_next = addr_reg + 17'h0_0001;
                        end
                    end
                end else begin
                    so_next = out_sh_reg[7];
                    out_sh_next = {out_sh_reg[6:0], 1'b0};
                    out_cnt_next = out_cnt_reg - 3'h1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= SEC_IDLE;
            cmd_reg <= SEC_CMD_NONE;
            bit_cnt_reg <= 5'h00;
            sh_reg <= 24'h00_0000;
            out_cnt_reg <= 3'h0;
            out_sh_reg <= 8'h00;
            so_reg <= 1'b0;
            done_reg <= 1'b0;
            ppe_reg <= 1'b0;
            ids_reg <= 1'b0;
            lock_reg <= 1'b0;
            bp_reg <= 2'h0;
            wel_reg <= 1'b0;
            busy_reg <= 1'b0;
            wc_cnt_reg <= '0;
            addr_reg <= 17'h0_0000;
            wdata_reg <= 8'h00;
            wr_pulse_reg <= 1'b0;
            commit_reg <= 1'b0;
            stat_data_reg <= 8'h00;
        end else if (clk_en) begin
            state_reg <= state_next;
            cmd_reg <= cmd_next;
            bit_cnt_reg <= bit_cnt_next;
            sh_reg <= sh_next;
            out_cnt_reg <= out_cnt_next;
            out_sh_reg <= out_sh_next;
            so_reg <= so_next;
            done_reg <= done_next;
            ppe_reg <= ppe_next;
            ids_reg <= ids_next;
            lock_reg <= lock_next;
            bp_reg <= bp_next;
            wel_reg <= wel_next;
            busy_reg <= busy_next;
            wc_cnt_reg <= wc_cnt_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            wr_pulse_reg <= wr_pulse_next;
            commit_reg <= commit_next;
            stat_data_reg <= stat_data_next;
        end
    end

    // Output drives only in a read phase with chip select low and no pause
    assign so_oe = ~pin.cs_n & pin.hold_n
        & (state_reg == SEC_RDATA || state_reg == SEC_RSTAT);
    assign so_out = so_reg;
    assign mem_addr = addr_reg;
    assign mem_id_sel = ids_reg;
    assign mem_wdata = wdata_reg;
    assign mem_wr_pulse = wr_pulse_reg;
    assign mem_commit = commit_reg;
    assign status_out = status;
    assign busy = busy_reg;

    so_hiz_a: assert property (@(posedge clk) disable iff (!arst_n)
        pin.cs_n |-> !so_oe) else $error("Output driven with chip select high");

    so_fall_a: assert property (@(posedge clk) disable iff (!arst_n)
        $changed(so_reg) |-> $past(pin.sck_fall)) else $error("Output moved off a falling edge");

    rise_step_a: assert property (@(posedge clk) disable iff (!arst_n)
        (bit_cnt_reg != $past(bit_cnt_reg)) && !$past(pin.cs_fall) |-> $past(pin.sck_rise))
        else $error("Bit count moved without a rising edge");

    hold_freeze_a: assert property (@(posedge clk) disable iff (!arst_n)
        !pin.hold_n && !pin.cs_fall && !pin.cs_rise |=> $stable(bit_cnt_reg) && $stable(so_reg))
        else $error("Serial state moved during hold");

    busy_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && busy_reg && state_reg == SEC_OPC && pin.sck_rise && pin.hold_n && !pin.cs_rise
        && bit_cnt_reg == `SEC_OPC_LAST |=> state_reg == SEC_IGNORE || state_reg == SEC_RSTAT)
        else $error("Instruction accepted while busy");

    wp_block_a: assert property (@(posedge clk) disable iff (!arst_n)
        pin.cs_rise && cmd_reg == SEC_CMD_WRS && !pin.wp_n && ppe_reg
        |=> $stable(status[7:2]) && !$rose(busy_reg)) else $error("Status written under pin protect");

    commit_busy_a: assert property (@(posedge clk) disable iff (!arst_n)
        mem_commit |-> busy_reg && wc_cnt_reg == WCW'(WC_CYCLES) && !ids_reg)
        else $error("Write cycle not started on commit");

    busy_end_a: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(busy_reg) |-> $past(wc_cnt_reg) == WCW'(1) && !wel_reg)
        else $error("Write cycle ended early");

    lock_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
        lock_reg |=> lock_reg) else $error("ID page lock released");

    bad_op_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == SEC_IGNORE && !pin.cs_fall |=> state_reg == SEC_IGNORE || state_reg == SEC_IDLE)
        else $error("Left ignore before chip select high");
endmodule

//--- src/sec_defines.svh
// Constants of the serial EEPROM command front end
`ifndef SEC_DEFINES_SVH
`define SEC_DEFINES_SVH

// Opcodes
`define SEC_OP_SET_WEL 8'h06
`define SEC_OP_CLR_WEL 8'h04
`define SEC_OP_RD_STAT 8'h05
`define SEC_OP_WR_STAT 8'h01
`define SEC_OP_MEM_RD 8'h03
`define SEC_OP_MEM_WR 8'h02

// Status bit positions
`define SEC_ST_PPE 7
`define SEC_ST_IDS 6
`define SEC_ST_LOCK 4
`define SEC_ST_BP_LO 2
`define SEC_ST_BP_HI 3
`define SEC_ST_WEL 1
`define SEC_ST_BUSY 0

// Pin vector positions and reset value {wp_n, hold_n, cs_n, si, sck}
`define SEC_PIN_SCK 0
`define SEC_PIN_SI 1
`define SEC_PIN_CS 2
`define SEC_PIN_HOLD 3
`define SEC_PIN_WP 4
`define SEC_PIN_RST 5'h1C

// Serial bit counts
`define SEC_OPC_LAST 5'h07
`define SEC_ADDR_LAST 5'h1F
`define SEC_STAT_LAST 5'h0F

// Timing
`define SEC_CLK_HZ 20000000
`define SEC_T_WC_MS 5
`define SEC_WC_CYCLES (`SEC_T_WC_MS * (`SEC_CLK_HZ / 1000))

`endif

//--- src/sec_pkg.sv
// Types of the serial EEPROM command front end
package sec_pkg;
    parameter int SEC_PIN_W = 5;

    typedef enum logic [2:0] {
        SEC_IDLE = 3'h0,
        SEC_OPC = 3'h1,
        SEC_ADDR = 3'h3,
        SEC_WDATA = 3'h2,
        SEC_RDATA = 3'h6,
        SEC_RSTAT = 3'h7,
        SEC_WSTAT = 3'h5,
        SEC_IGNORE = 3'h4
    } sec_state_e;

    typedef enum logic [2:0] {
        SEC_CMD_NONE = 3'h0,
        SEC_CMD_SETW = 3'h1,
        SEC_CMD_CLRW = 3'h2,
        SEC_CMD_RDS = 3'h3,
        SEC_CMD_WRS = 3'h4,
        SEC_CMD_RD = 3'h5,
        SEC_CMD_WR = 3'h6
    } sec_cmd_e;
endpackage

//--- src/sec_pin_if.sv
// Synchronised pin levels and serial clock edges
`timescale 1ns/100ps
interface sec_pin_if;
    logic sck_rise;
    logic sck_fall;
    logic cs_n;
    logic cs_rise;
    logic cs_fall;
    logic si;
    logic hold_n;
    logic wp_n;
    modport src(output sck_rise, sck_fall, cs_n, cs_rise, cs_fall, si, hold_n, wp_n);
    modport dst(input sck_rise, sck_fall, cs_n, cs_rise, cs_fall, si, hold_n, wp_n);
endinterface

//--- src/sec_pin_sync.sv
// Two-stage pin synchronisers and edge finders
`timescale 1ns/100ps
`include "sec_defines.svh"
module sec_pin_sync
    import sec_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Raw pins
    input wire logic [SEC_PIN_W-1:0] pins_raw,
    // Clean view
    sec_pin_if.src pin
);
    logic [SEC_PIN_W-1:0] s1_reg, s2_reg, s3_reg;
    logic [SEC_PIN_W-1:0] s1_next, s2_next, s3_next;

    genvar gi;
    generate
        for (gi = 0; gi < SEC_PIN_W; gi++) begin : g_bit
            always_comb begin
                s1_next[gi] = pins_raw[gi];
                s2_next[gi] = s1_reg[gi];
                s3_next[gi] = s2_reg[gi];
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_reg <= `SEC_PIN_RST;
            s2_reg <= `SEC_PIN_RST;
            s3_reg <= `SEC_PIN_RST;
        end else if (clk_en) begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
        end
    end

    // Edges seen between stages two and three only
    assign pin.sck_rise = s2_reg[`SEC_PIN_SCK] & ~s3_reg[`SEC_PIN_SCK];
    assign pin.sck_fall = ~s2_reg[`SEC_PIN_SCK] & s3_reg[`SEC_PIN_SCK];
    assign pin.cs_rise = s2_reg[`SEC_PIN_CS] & ~s3_reg[`SEC_PIN_CS];
    assign pin.cs_fall = ~s2_reg[`SEC_PIN_CS] & s3_reg[`SEC_PIN_CS];
    assign pin.cs_n = s2_reg[`SEC_PIN_CS];
    assign pin.si = s2_reg[`SEC_PIN_SI];
    assign pin.hold_n = s2_reg[`SEC_PIN_HOLD];
    assign pin.wp_n = s2_reg[`SEC_PIN_WP];
endmodule

//--- verif/sec_host_model.sv
// Host serial master model for the command front end
`timescale 1ns/100ps
module sec_host_model (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic sck,
    output logic cs_n,
    output logic si,
    output logic hold_n,
    input wire logic so_out,
    input wire logic so_oe
);
    logic cpol = 1'b0;
    logic oe_seen = 1'b0;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
    end
    always @(posedge clk) begin
        if (cs_n === 1'b0 && so_oe === 1'b1) begin
            oe_seen <= 1'b1;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Idle level only changes between frames
    task automatic set_mode(input logic p);
        cpol = p;
        sck <= p;
        tick(6);
    endtask
    // SI moves while the clock is low, SO is sampled at the rise
    task automatic xfer(input int n, input logic [7:0] tx [6], output logic [7:0] rx [6],
                        input bit pause);
        tick(1);
        oe_seen <= 1'b0;
        cs_n <= 1'b0;
        tick(4);
        for (int b = 0; b < n; b++) begin
            for (int i = 7; i >= 0; i--) begin
                sck <= 1'b0;
                si <= tx[b][i];
                tick(4);
                if (pause && b == 0 && i == 4) begin
                    hold_n <= 1'b0;
                    si <= ~tx[b][i];
                    tick(4);
                    sck <= 1'b1;
                    tick(4);
                    sck <= 1'b0;
                    tick(4);
                    si <= tx[b][i];
                    hold_n <= 1'b1;
                    tick(4);
                end
                sck <= 1'b1;
                rx[b][i] = so_out;
                tick(4);
            end
        end
        sck <= cpol;
        tick(4);
        cs_n <= 1'b1;
        si <= ~si;
        tick(6);
    endtask
endmodule

//--- verif/sec_eeprom_cmd_test.sv
// Self-checking bench of the serial EEPROM command front end
`timescale 1ns/100ps
`include "sec_defines.svh"
module sec_eeprom_cmd_test;
    logic clk;
    logic arst_n = 1'b0;
    logic wp_n = 1'b1;
    logic sck;
    logic cs_n;
    logic si;
    logic hold_n;
    logic so_out;
    logic so_oe;
    logic [16:0] mem_addr;
    logic mem_id_sel;
    logic [7:0] mem_wdata;
    logic mem_wr_pulse;
    logic mem_commit;
    int commit_n = 0;
    logic [7:0] mem_rdata;
    logic [7:0] status_out;
    logic busy;
    int err_total = 0;
    int n_compared = 0;
    int wr_n = 0;
    int cs_hi = 0;
    int base;
    logic [16:0] wr_addr [8];
    logic [7:0] wr_data [8];
    logic [7:0] tx [6];
    logic [7:0] rx [6];

    // Array stand-in: data is a fixed function of the address
    assign mem_rdata = mem_addr[7:0] ^ 8'h5A;

    sec_eeprom_cmd #(.WC_CYCLES(400)) i_sec_eeprom_cmd (
        .clk(clk), .arst_n(arst_n), .clk_en(1'b1), .sck(sck), .cs_n(cs_n), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe), .mem_addr(mem_addr),
        .mem_id_sel(mem_id_sel), .mem_wdata(mem_wdata), .mem_wr_pulse(mem_wr_pulse),
        .mem_commit(mem_commit), .mem_rdata(mem_rdata), .status_out(status_out), .busy(busy));
    sec_host_model i_sec_host_model (
        .clk(clk), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so_out(so_out),
        .so_oe(so_oe));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        if (err_total == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic send(input int n, input bit pause);
        i_sec_host_model.xfer(n, tx, rx, pause);
    endtask
    task automatic op1(input logic [7:0] op);
        tx = '{op, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        send(1, 1'b0);
    endtask
    // Status byte is repeated while the clock keeps running
    task automatic rd_stat(input logic [7:0] exp, input bit pause);
        tx = '{`SEC_OP_RD_STAT, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        send(3, pause);
        chk(rx[1], exp);
        chk(rx[2], exp);
    endtask
    task automatic wr_stat(input logic [7:0] val);
        op1(`SEC_OP_SET_WEL);
        tx = '{`SEC_OP_WR_STAT, val, 8'h00, 8'h00, 8'h00, 8'h00};
        send(2, 1'b0);
    endtask
    task automatic idle_wait();
        for (int k = 0; k < 420 && busy !== 1'b0; k++) begin
            @(negedge clk);
        end
        chk(busy, 1'b0);
    endtask

    // Output must be off once chip select has settled high
    always @(posedge clk) begin
        cs_hi <= (cs_n === 1'b1) ? cs_hi + 1 : 0;
        if (cs_hi > 4 && so_oe !== 1'b0) begin
            chk(so_oe, 1'b0);
        end
        if (mem_commit === 1'b1) begin
            commit_n <= commit_n + 1;
        end
        if (mem_wr_pulse === 1'b1) begin
            wr_addr[wr_n % 8] <= mem_addr;
            wr_data[wr_n % 8] <= mem_wdata;
            wr_n <= wr_n + 1;
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        chk(status_out, 8'h00);
        chk(so_oe, 1'b0);
        arst_n <= 1'b1;
        // Reset release stands in for supply settling
        repeat (20000) @(posedge clk);
        rd_stat(8'h00, 1'b0);
        op1(`SEC_OP_SET_WEL);
        rd_stat(8'h02, 1'b1);
        op1(`SEC_OP_CLR_WEL);
        rd_stat(8'h00, 1'b0);
        tx = '{8'h0B, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
        send(4, 1'b0);
        chk(i_sec_host_model.oe_seen, 1'b0);
        wr_stat(8'h8C);
        chk(busy, 1'b1);
        op1(`SEC_OP_CLR_WEL);
        rd_stat(8'h8F, 1'b0);
        idle_wait();
        rd_stat(8'h8C, 1'b0);
        wp_n <= 1'b0;
        wr_stat(8'h00);
        chk(busy, 1'b0);
        rd_stat(8'h8E, 1'b0);
        wp_n <= 1'b1;
        wr_stat(8'h00);
        idle_wait();
        rd_stat(8'h00, 1'b0);
        base = wr_n;
        op1(`SEC_OP_SET_WEL);
        tx = '{`SEC_OP_MEM_WR, 8'h00, 8'h01, 8'hFF, 8'hA1, 8'hB2};
        send(6, 1'b0);
        chk(17'(wr_n - base), 17'h0_0002);
        chk(wr_addr[base % 8], 17'h0_01FF);
        chk(wr_data[base % 8], 8'hA1);
        chk(wr_addr[(base + 1) % 8], 17'h0_0100);
        chk(wr_data[(base + 1) % 8], 8'hB2);
        chk(17'(commit_n), 17'h0_0001);
        chk(busy, 1'b1);
        tx = '{`SEC_OP_MEM_RD, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00};
        send(5, 1'b0);
        chk(i_sec_host_model.oe_seen, 1'b0);
        idle_wait();
        i_sec_host_model.set_mode(1'b1);
        send(6, 1'b0);
        chk(rx[4], 8'h10 ^ 8'h5A);
        chk(rx[5], 8'h11 ^ 8'h5A);
        i_sec_host_model.set_mode(1'b0);
        wr_stat(8'h40);
        idle_wait();
        rd_stat(8'h40, 1'b0);
        chk(mem_id_sel, 1'b1);
        tx = '{`SEC_OP_MEM_RD, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00};
        send(5, 1'b0);
        chk(rx[4], 8'h05 ^ 8'h5A);
        chk(mem_id_sel, 1'b0);
        rd_stat(8'h00, 1'b0);
        wr_stat(8'h10);
        idle_wait();
        wr_stat(8'h40);
        idle_wait();
        base = wr_n;
        op1(`SEC_OP_SET_WEL);
        tx = '{`SEC_OP_MEM_WR, 8'h00, 8'h00, 8'h00, 8'h33, 8'h00};
        send(5, 1'b0);
        chk(17'(wr_n - base), 17'h0_0000);
        chk(busy, 1'b0);
        chk(17'(commit_n), 17'h0_0001);
        wr_stat(8'h00);
        idle_wait();
        rd_stat(8'h10, 1'b0);
        summarize();
    end

    // Whole sequence takes near 28000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        summarize();
    end
endmodule
